// [hw/lp_consts.vh]
// constants for the dram low-power state logic
// assumes a 125 MHz core clock standing in for the memory clock
`ifndef LP_CONSTS_VH
`define LP_CONSTS_VH

`define CLK_PERIOD_PS      32'd8000
`define T_CKE_PS           32'd5000
`define T_CPDED_NCK        8'h01
`define CKE_CYC            (((`T_CKE_PS + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS) > 32'd0 ? ((`T_CKE_PS + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS) : 32'd1)
`define REF_INTERVAL_CYC   32'd64
`define MR0_PPD_BIT        12
`define MR1_DLL_DIS_BIT    0

`define ST_IDLE            3'h0
`define ST_SELF_REF        3'h1
`define ST_PD_PRE          3'h2
`define ST_PD_ACT          3'h3
`define ST_RESET           3'h4

`endif

// [hw/lp_ctrl.v]
// What this block does
// - CS RAS CAS CKE low, WE high: self-refresh
// - DLL off on entry, on with reset at exit
// - self-refresh ignores all but CKE and reset
// - internal refresh starts two cycles after entry, later than tCKE
// - exit on CKE high with NOP/deselect
// - CKE low with NOP/deselect enters power-down
// - banks closed: precharge, else active power-down
// - buffers off, command receivers off after tCPDED
// - A12 picks slow or fast exit DLL in precharge power-down; active is always fast
// - reset low leaves power-down into reset
//
// decodes pin commands registered on the memory clock and keeps the
// low-power state, DLL state and buffer enables of the device
`timescale 1ns/1ps
`include "lp_consts.vh"

module lp_ctrl #(
    parameter REF_INTERVAL = 64,
    parameter CPDED_NCK    = 1
) (
    // clock and reset
    input  wire        CORE_CLK_I,
    input  wire        SYS_RST_I,
    // memory pins, already in the clock domain
    input  wire        CKE_I,
    input  wire        CS_N_I,
    input  wire        RAS_N_I,
    input  wire        CAS_N_I,
    input  wire        WE_N_I,
    input  wire        DRAM_RST_N_I,
    // mode bits and bank state from the core
    input  wire        MR0_PPD_I,
    input  wire        MR1_DLL_DIS_I,
    input  wire        ANY_BANK_OPEN_I,
    // status outputs
    output reg  [2:0]  STATE_O,
    output reg         DLL_ON_O,
    output reg         DLL_RESET_O,
    output reg         INT_REFRESH_O,
    output reg         IO_BUF_EN_O,
    output reg         CMD_RX_EN_O,
    output reg         CLK_INT_EN_O,
    output reg         FAST_EXIT_O
);
    // ****************************************************************
    // command decode
    // ****************************************************************
    reg         cke_prev_q;
    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [7:0]  cpded_q;
    reg         dll_en_q;
    wire        ref_tick;
    wire        nop_or_des;
    wire        sre_cmd;
    // receiver switch-off delay, sized to the counter it is compared with
    localparam [7:0] CPDED_LIM = CPDED_NCK;

    assign nop_or_des = CS_N_I | (RAS_N_I & CAS_N_I & WE_N_I);
    assign sre_cmd = cke_prev_q & ~CKE_I & ~CS_N_I & ~RAS_N_I & ~CAS_N_I & WE_N_I;

    // ****************************************************************
    // state machine
    // ****************************************************************
    always @* begin
        state_d = state_q;
        case (state_q)
            `ST_RESET: begin
                if (DRAM_RST_N_I)
                    state_d = `ST_IDLE;
            end
            `ST_IDLE: begin
                if (sre_cmd)
                    state_d = `ST_SELF_REF;
                else if (cke_prev_q && !CKE_I && nop_or_des)
                    state_d = ANY_BANK_OPEN_I ? `ST_PD_ACT : `ST_PD_PRE;
            end
            `ST_SELF_REF: begin
                // exit on CKE high with NOP/deselect
                if (CKE_I && nop_or_des)
                    state_d = `ST_IDLE;
            end
            `ST_PD_PRE, `ST_PD_ACT: begin
                // bank state settles after in-flight commands
                if (ANY_BANK_OPEN_I)
                    state_d = `ST_PD_ACT;
                else
                    state_d = `ST_PD_PRE;
                if (CKE_I)
                    state_d = `ST_IDLE;
            end
            default: state_d = `ST_IDLE;
        endcase
        // reset pin wins in every state
        if (!DRAM_RST_N_I)
            state_d = `ST_RESET;
    end

    always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_q    <= `ST_RESET;
            cke_prev_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            cke_prev_q <= CKE_I;
        end
    end

    // ****************************************************************
    // internal refresh while in self-refresh
    // ****************************************************************
    // timer fires on the second cycle of self-refresh
    ref_timer #(
        .INTERVAL (REF_INTERVAL)
    ) u_ref_timer (
        .clk    (CORE_CLK_I),
        .rst    (SYS_RST_I),
        .run    (state_q == `ST_SELF_REF),
        .tick_q (ref_tick)
    );

    // ****************************************************************
    // dll, buffers and receivers
    // ****************************************************************
    always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            dll_en_q      <= 1'b0;
            cpded_q       <= 8'h00;
            STATE_O       <= `ST_RESET;
            DLL_ON_O      <= 1'b0;
            DLL_RESET_O   <= 1'b0;
            INT_REFRESH_O <= 1'b0;
            IO_BUF_EN_O   <= 1'b0;
            CMD_RX_EN_O   <= 1'b0;
            CLK_INT_EN_O  <= 1'b0;
            FAST_EXIT_O   <= 1'b0;
        end else begin
            dll_en_q      <= ~MR1_DLL_DIS_I;
            STATE_O       <= state_d;
            INT_REFRESH_O <= ref_tick;
            DLL_RESET_O   <= 1'b0;
            case (state_d)
                `ST_SELF_REF: begin
                    DLL_ON_O     <= 1'b0;
                    CLK_INT_EN_O <= 1'b0;
                    IO_BUF_EN_O  <= 1'b0;
                    CMD_RX_EN_O  <= 1'b0;
                    FAST_EXIT_O  <= 1'b0;
                end
                `ST_PD_PRE, `ST_PD_ACT: begin
                    // slow exit only for precharge with A12 low
                    if (state_d == `ST_PD_PRE && !MR0_PPD_I) begin
                        DLL_ON_O    <= 1'b0;
                        FAST_EXIT_O <= 1'b0;
                    end else begin
                        DLL_ON_O    <= ~MR1_DLL_DIS_I;
                        FAST_EXIT_O <= 1'b1;
                    end
                    CLK_INT_EN_O <= 1'b1;
                    IO_BUF_EN_O  <= 1'b0;
                    if (cpded_q >= CPDED_LIM)
                        CMD_RX_EN_O <= 1'b0;
                    else
                        cpded_q <= cpded_q + 8'h01;
                end
                `ST_IDLE: begin
                    // dll restart with reset after self-refresh
                    if (state_q == `ST_SELF_REF && dll_en_q)
                        DLL_RESET_O <= 1'b1;
                    DLL_ON_O     <= ~MR1_DLL_DIS_I;
                    CLK_INT_EN_O <= 1'b1;
                    IO_BUF_EN_O  <= 1'b1;
                    CMD_RX_EN_O  <= 1'b1;
                    FAST_EXIT_O  <= 1'b0;
                    cpded_q      <= 8'h00;
                end
                default: begin
                    DLL_ON_O     <= 1'b0;
                    CLK_INT_EN_O <= 1'b0;
                    IO_BUF_EN_O  <= 1'b0;
                    CMD_RX_EN_O  <= 1'b0;
                    FAST_EXIT_O  <= 1'b0;
                    cpded_q      <= 8'h00;
                end
            endcase
        end
    end
endmodule // lp_ctrl

// [hw/ref_timer.v]
// internal refresh timer used while in self-refresh
// assumes run is a same-clock level from the state logic
`timescale 1ns/1ps
`include "lp_consts.vh"

module ref_timer #(
    parameter INTERVAL = 64
) (
    input  wire clk,
    input  wire rst,
    input  wire run,
    output reg  tick_q
);
    reg [31:0] cnt_q;

    // first tick a single cycle after start, 8 ns, longer than the 5 ns tCKE
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q  <= 32'h0;
            tick_q <= 1'b0;
        end else if (!run) begin
            cnt_q  <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (cnt_q == 32'h0);
            if (cnt_q >= INTERVAL - 1)
                cnt_q <= 32'h0;
            else
                cnt_q <= cnt_q + 32'h1;
        end
    end
endmodule // ref_timer

// [verification/lp_ctrl_props.sv]
// assertions on the ports of the low-power state logic
// assumes the bind at the foot of this file
`timescale 1ns/1ps
module lp_ctrl_props (
    input wire       CORE_CLK_I, SYS_RST_I, CKE_I, CS_N_I, RAS_N_I, CAS_N_I, WE_N_I,
    input wire       DRAM_RST_N_I, MR0_PPD_I, MR1_DLL_DIS_I, ANY_BANK_OPEN_I,
    input wire [2:0] STATE_O,
    input wire       DLL_ON_O, DLL_RESET_O, INT_REFRESH_O, IO_BUF_EN_O, CMD_RX_EN_O,
    input wire       CLK_INT_EN_O, FAST_EXIT_O
);
    wire nop = CS_N_I | (RAS_N_I & CAS_N_I & WE_N_I);
    wire sre = !CKE_I & !CS_N_I & !RAS_N_I & !CAS_N_I & WE_N_I;
    wire pd  = (STATE_O == 3'h2) | (STATE_O == 3'h3);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // ****
    // state checks
    // ****
    sr_enter_a: assert property (
        $past(CKE_I) && sre && STATE_O == 3'h0 |=> STATE_O == 3'h1) else $error("no entry");
    sr_dll_a: assert property (
        STATE_O == 3'h1 |-> !DLL_ON_O && !CLK_INT_EN_O) else $error("dll or clock on");
    sr_refresh_a: assert property (
        $rose(STATE_O == 3'h1) |-> ##2 INT_REFRESH_O) else $error("no first refresh");
    sr_hold_a: assert property (
        STATE_O == 3'h1 && !CKE_I && DRAM_RST_N_I |=> STATE_O == 3'h1) else $error("left sr");
    sr_exit_a: assert property (
        STATE_O == 3'h1 && CKE_I && nop && DRAM_RST_N_I |=> STATE_O == 3'h0
        && DLL_RESET_O == !MR1_DLL_DIS_I && DLL_ON_O == !MR1_DLL_DIS_I) else $error("bad exit");
    pd_enter_a: assert property (
        STATE_O == 3'h0 && $past(CKE_I) && !CKE_I && nop && DRAM_RST_N_I
        |=> STATE_O == ($past(ANY_BANK_OPEN_I) ? 3'h3 : 3'h2)) else $error("bad pd entry");
    pd_buf_a: assert property (pd |-> !IO_BUF_EN_O) else $error("buffers on");
    pd_rx_a: assert property (pd [*3] |-> !CMD_RX_EN_O) else $error("receivers on");
    pd_dll_a: assert property (
        STATE_O == 3'h2 |-> FAST_EXIT_O == MR0_PPD_I
        && DLL_ON_O == (MR0_PPD_I & !MR1_DLL_DIS_I)) else $error("bad precharge pd dll");
    act_fast_a: assert property (
        STATE_O == 3'h3 |-> FAST_EXIT_O) else $error("active pd not fast");
    pin_rst_a: assert property (
        !DRAM_RST_N_I |=> STATE_O == 3'h4) else $error("reset pin ignored");
    cover property (STATE_O == 3'h1 && INT_REFRESH_O);
    cover property (STATE_O == 3'h3);
    cover property (DLL_RESET_O);
endmodule // lp_ctrl_props

bind lp_ctrl lp_ctrl_props u_props (.*);

// [verification/mc_model.sv]
// controller stand-in: turns a bench opcode into command pin levels
// assumes op_i changes just after a clock edge
`timescale 1ns/1ps
module mc_model (
    input  wire       clk_i,
    input  wire [1:0] op_i,
    output reg  [4:0] pins_o
);
    // ignored pins still toggle, so a stale level never looks valid
    reg [3:0] junk_q = 4'h3;
    always @(posedge clk_i) begin
        junk_q <= junk_q + 4'h5;
    end
    always @* begin
        case (op_i)
            2'h1: pins_o = 5'h01;
            2'h2: pins_o = {1'b0, junk_q};
            2'h3: pins_o = 5'h0f;
            // no write, read or odt is ever issued after an exit
            // clock never stops; self-refresh lasts 18 cycles
            // power-down lasts a few cycles, no refresh is postponed
            default: pins_o = 5'h1f;
        endcase
    end
endmodule // mc_model

// [verification/tb_sdram_self_refresh_power_down.sv]
// bench for the dram low-power state logic
// assumes mc_model drives the command pins
`timescale 1ns/1ps
module tb_sdram_self_refresh_power_down;
    reg        clk = 1'b0, rst = 1'b1, rst_n = 1'b1;
    reg        ppd = 1'b0, dis = 1'b0, bank_open = 1'b0;
    reg  [1:0] op = 2'h0;
    wire [4:0] pins;
    wire [2:0] state;
    wire       dll_on, dll_rst, iref, io_en, rx_en, clk_en, fast;
    integer    n_mismatch = 0, check_count = 0, cyc = 0, i, n;
    mc_model u_mc (.clk_i(clk), .op_i(op), .pins_o(pins));
    lp_ctrl #(.REF_INTERVAL(8), .CPDED_NCK(1)) DUT (
        .CORE_CLK_I(clk), .SYS_RST_I(rst), .CKE_I(pins[4]), .CS_N_I(pins[3]),
        .RAS_N_I(pins[2]), .CAS_N_I(pins[1]), .WE_N_I(pins[0]), .DRAM_RST_N_I(rst_n),
        .MR0_PPD_I(ppd), .MR1_DLL_DIS_I(dis), .ANY_BANK_OPEN_I(bank_open),
        .STATE_O(state), .DLL_ON_O(dll_on), .DLL_RESET_O(dll_rst), .INT_REFRESH_O(iref),
        .IO_BUF_EN_O(io_en), .CMD_RX_EN_O(rx_en), .CLK_INT_EN_O(clk_en), .FAST_EXIT_O(fast));
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end
    end
    // ****
    // tasks
    // ****
    task chk(input [2:0] g, input [2:0] e);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %0t got %h want %h", $time, g, e);
            end
        end
    endtask
    // op is sampled at the next edge, and looked at just after it
    task step(input [1:0] o);
        begin
            @(posedge clk) op <= o;
            @(posedge clk) #1;
        end
    endtask
    task t_sr(input d);
        begin
            @(posedge clk) dis <= d;
            step(2'h1);
            chk(state, 3'h1);
            chk({1'b0, dll_on, clk_en}, 3'h0);
            @(posedge clk) op <= 2'h2;
            #1 n = iref;
            repeat (15) begin
                @(posedge clk) #1;
                n = n + iref;
            end
            chk(n[2:0], 3'h2);
            chk(state, 3'h1);
            step(2'h0);
            chk(state, 3'h0);
            chk({dll_rst, dll_on, clk_en}, {~d, ~d, 1'b1});
            step(2'h0);
            $display("self-refresh test done");
        end
    endtask
    task t_pd(input b, input p);
        begin
            @(posedge clk) begin
                bank_open <= b;
                ppd <= p;
            end
            step(2'h3);
            chk(state, b ? 3'h3 : 3'h2);
            repeat (3) @(posedge clk);
            #1 chk({io_en | rx_en, fast, dll_on}, {1'b0, b | p, b | p});
            step(2'h0);
            chk(state, 3'h0);
            $display("power-down test done");
        end
    endtask
    task t_rst;
        begin
            step(2'h3);
            @(posedge clk) rst_n <= 1'b0;
            @(posedge clk) #1 chk(state, 3'h4);
            @(posedge clk) begin
                rst_n <= 1'b1;
                op <= 2'h0;
            end
            repeat (3) @(posedge clk);
            #1 chk(state, 3'h0);
            $display("reset pin test done");
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", check_count, n_mismatch);
            if (n_mismatch == 0 && check_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 chk(state, 3'h4);
        @(posedge clk) rst <= 1'b0;
        step(2'h0);
        chk(state, 3'h0);
        t_sr(1'b1);
        t_sr(1'b0);
        for (i = 0; i < 4; i = i + 1)
            t_pd(i[0], i[1]);
        t_rst;
        stop_test;
    end
endmodule // tb_sdram_self_refresh_power_down
